// file: eeprom_pkg.sv
// Notes on behaviour
// [RQ1] SDA fall/rise with SCL high: start/stop
// [RQ2] Eight-bit bytes, receiver acknowledges on ninth clock
// [RQ3] Small parts: select bits must match pins
// [RQ4] Large parts: select bits become address MSBs
// [RQ5] Last address bit: high reads, low writes
// [RQ6] Match acknowledges low; mismatch returns to standby
// [RQ7] Byte write: word address, then data, acked
// [RQ8] Master stop after data launches programming
// [RQ9] Programming ends within the write cycle time
// [RQ10] Busy programming: inputs ignored, no response
// [RQ11] Page of 8 or 16 bytes
// [RQ12] Page write: further bytes, each acknowledged
// [RQ13] Write increments low page bits, wraps
// [RQ14] Address polled: acknowledged only after programming
// [RQ15] Address counter keeps last address plus one
// [RQ16] Reads wrap whole memory, writes wrap page
// [RQ17] Read acknowledged: send byte at counter
// [RQ18] Random read: dummy write, repeated start, read
// [RQ19] Master acknowledge: advance and send next byte
// [RQ20] Master ends read with no-ack, stop
// [RQ21] After mismatch ignore bus until start
package eeprom_pkg;

  // Capacity is fixed here; 8 address bits gives the 256 byte part.
  localparam int MEM_ADDR_W = 8;
  localparam int MEM_BYTES  = 1 << MEM_ADDR_W;
  localparam int PAGE_SEL_W = (MEM_ADDR_W > 8) ? MEM_ADDR_W - 8 : 0;
  localparam int PAGE_LOW_W = (MEM_ADDR_W > 8) ? 4 : 3;

  typedef logic [MEM_ADDR_W-1:0] mem_addr_type;

  localparam mem_addr_type PAGE_MASK      = mem_addr_type'((1 << PAGE_LOW_W) - 1);
  localparam logic [3:0]   DEV_TYPE_CODE  = 4'ha;
  localparam logic [2:0]   PIN_MATCH_MASK = 3'(3'h7 << PAGE_SEL_W);
  localparam logic [3:0]   LAST_BIT       = 4'h7;
  localparam logic [3:0]   ACK_SLOT       = 4'h8;

  localparam int REF_CLK_KHZ  = 40000;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYCLES  = PROG_TIME_MS * REF_CLK_KHZ;
  localparam int SCL_KHZ      = 400;
  localparam int SCL_QUARTER_CYCLES = (REF_CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
  localparam int SCL_QW       = $clog2(SCL_QUARTER_CYCLES);

  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_STOP  = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_READ  = 2'h3
  } cmd_type;

endpackage

// file: eeprom_link_if.sv
interface eeprom_link_if;
  logic scl;
  logic sda;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;

  // Open-drain wire with pull-up: any enabled driver showing 0 pulls it low.
  assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));

  modport device (
    input  scl,
    input  sda,
    output dev_sda_out,
    output dev_sda_oe
  );

  modport host (
    output scl,
    output host_sda_out,
    output host_sda_oe,
    input  sda
  );
endinterface

// file: eeprom_device.sv
module eeprom_device
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  input  wire logic     REF_CLK,
  input  wire logic     RESET_N,
  input  wire logic     SELECT_PIN_HIGH,
  input  wire logic     SELECT_PIN_MID,
  input  wire logic     SELECT_PIN_LOW,
  output logic          BUSY,
  eeprom_link_if.device LINK
);

  localparam int PROG_W = $clog2(PROG_CYCLES_P + 1);

  typedef enum logic [4:0] {
    L_DEV    = 5'h01,
    L_WADDR  = 5'h02,
    L_WDATA  = 5'h04,
    L_RDATA  = 5'h08,
    L_IGNORE = 5'h10
  } link_state_type;

  typedef struct packed {
    link_state_type state;
    logic [3:0]     bit_cnt;
    logic [7:0]     shift;
    logic [7:0]     tx;
    logic [2:0]     dev_sel;
    logic           read_op;
    logic           drive_low;
    logic           armed;
    logic           busy_s1;
    logic           busy_s2;
    logic [2:0]     pins_s1;
    logic [2:0]     pins_s2;
  } link_regs_type;

  typedef struct packed {
    logic              scl_s1;
    logic              scl_s2;
    logic              scl_s3;
    logic              sda_s1;
    logic              sda_s2;
    logic              sda_s3;
    logic              armed_s1;
    logic              armed_s2;
    logic              frame;
    logic              restart;
    logic              busy;
    logic [PROG_W-1:0] prog_cnt;
  } ref_regs_type;

  ref_regs_type  ref_ff;
  ref_regs_type  nxt_ref;
  link_regs_type link_ff;
  link_regs_type nxt_link;
  logic          start_seen;
  logic          stop_seen;
  logic          link_rst_n;
  logic [7:0]    new_byte;
  logic          mem_we;
  mem_addr_type  addr_ff;
  mem_addr_type  nxt_addr;
  logic          oe_ff;
  logic [7:0]    mem [MEM_BYTES];

  function automatic logic dev_match(input logic [7:0] b, input logic [2:0] pins);
    return (b[7:4] == DEV_TYPE_CODE) && (((b[3:1] ^ pins) & PIN_MATCH_MASK) == 3'h0);
  endfunction

  function automatic mem_addr_type page_inc(input mem_addr_type a);
    mem_addr_type a1;
    a1 = a + 1'b1;
    return (a & ~PAGE_MASK) | (a1 & PAGE_MASK);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Reference clock side: start/stop watch and programming timer.

  always_comb begin
    nxt_ref          = ref_ff;
    nxt_ref.scl_s1   = LINK.scl;
    nxt_ref.scl_s2   = ref_ff.scl_s1;
    nxt_ref.scl_s3   = ref_ff.scl_s2;
    nxt_ref.sda_s1   = LINK.sda;
    nxt_ref.sda_s2   = ref_ff.sda_s1;
    nxt_ref.sda_s3   = ref_ff.sda_s2;
    nxt_ref.armed_s1 = link_ff.armed;
    nxt_ref.armed_s2 = ref_ff.armed_s1;
    start_seen = ref_ff.scl_s2 & ref_ff.scl_s3 & ref_ff.sda_s3 & ~ref_ff.sda_s2; // [RQ1]
    stop_seen  = ref_ff.scl_s2 & ref_ff.scl_s3 & ~ref_ff.sda_s3 & ref_ff.sda_s2; // [RQ1]
    // A start drops the frame for one cycle so the link logic restarts cleanly.
    nxt_ref.restart = start_seen;
    nxt_ref.frame   = (ref_ff.frame | ref_ff.restart) & ~start_seen & ~stop_seen; // [RQ21]
    if (stop_seen && ref_ff.armed_s2 && !ref_ff.busy) begin
      nxt_ref.prog_cnt = PROG_W'(PROG_CYCLES_P); // [RQ8] [RQ9]
    end else if (ref_ff.prog_cnt != '0) begin
      nxt_ref.prog_cnt = ref_ff.prog_cnt - 1'b1; // [RQ9]
    end
    nxt_ref.busy = (nxt_ref.prog_cnt != '0);
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ref_ff <= '0;
    end else begin
      ref_ff <= nxt_ref;
    end
  end

  assign BUSY = ref_ff.busy;

  // Outside a frame the link logic is held in reset, so it counts on no SCL
  // edge between a stop and the next start.
  assign link_rst_n = RESET_N & ref_ff.frame;

  //////////////////////////////////////////////////////////////////////////////
  // Link side, clocked by SCL: bits in on the rising edge.

  assign new_byte = {link_ff.shift[6:0], LINK.sda};

  always_comb begin
    nxt_link         = link_ff;
    nxt_link.busy_s1 = ref_ff.busy;
    nxt_link.busy_s2 = link_ff.busy_s1;
    nxt_link.pins_s1 = {SELECT_PIN_HIGH, SELECT_PIN_MID, SELECT_PIN_LOW};
    nxt_link.pins_s2 = link_ff.pins_s1;
    nxt_addr         = addr_ff;
    mem_we           = 1'b0;
    if (link_ff.bit_cnt != ACK_SLOT) begin
      nxt_link.bit_cnt = link_ff.bit_cnt + 1'b1; // [RQ2]
      nxt_link.shift   = new_byte;
      if (link_ff.state == L_RDATA) begin
        nxt_link.tx        = {link_ff.tx[6:0], 1'b0};
        nxt_link.drive_low = (link_ff.bit_cnt != LAST_BIT) && !link_ff.tx[6];
      end else if (link_ff.bit_cnt == LAST_BIT) begin
        case (link_ff.state)
          L_DEV: begin
            if (dev_match(new_byte, link_ff.pins_s2) && !link_ff.busy_s2) begin // [RQ3] [RQ10]
              nxt_link.drive_low = 1'b1; // [RQ6] [RQ14]
              nxt_link.dev_sel   = new_byte[3:1];
              nxt_link.read_op   = new_byte[0]; // [RQ5]
            end else begin
              nxt_link.state = L_IGNORE; // [RQ6] [RQ21]
            end
          end
          L_WADDR: begin
            nxt_link.drive_low = 1'b1; // [RQ7]
            // Page select bits sit above the word address byte.
            nxt_addr = mem_addr_type'({link_ff.dev_sel, new_byte}); // [RQ4]
          end
          L_WDATA: begin
            nxt_link.drive_low = 1'b1; // [RQ7] [RQ12]
            nxt_link.armed     = 1'b1;
            mem_we             = 1'b1;
            nxt_addr           = page_inc(addr_ff); // [RQ11] [RQ13] [RQ16]
          end
          default: begin
            nxt_link.drive_low = 1'b0;
          end
        endcase
      end
    end else begin
      nxt_link.bit_cnt   = 4'h0;
      nxt_link.drive_low = 1'b0;
      case (link_ff.state)
        L_DEV: begin
          if (link_ff.read_op) begin
            nxt_link.state     = L_RDATA; // [RQ17]
            nxt_link.tx        = mem[addr_ff];
            nxt_link.drive_low = !mem[addr_ff][7];
            nxt_addr           = addr_ff + 1'b1; // [RQ15] [RQ16]
          end else begin
            nxt_link.state = L_WADDR; // [RQ7]
          end
        end
        L_WADDR: begin
          nxt_link.state = L_WDATA;
        end
        L_RDATA: begin
          if (!LINK.sda) begin
            nxt_link.tx        = mem[addr_ff]; // [RQ19]
            nxt_link.drive_low = !mem[addr_ff][7];
            nxt_addr           = addr_ff + 1'b1; // [RQ15] [RQ16]
          end else begin
            nxt_link.state = L_IGNORE; // [RQ20]
          end
        end
        default: begin
          nxt_link.state = link_ff.state;
        end
      endcase
    end
  end

  always_ff @(posedge LINK.scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      link_ff       <= '0;
      link_ff.state <= L_DEV;
    end else begin
      link_ff <= nxt_link;
    end
  end

  // The counter outlives frames, so only the power-on reset touches it.
  always_ff @(posedge LINK.scl or negedge RESET_N) begin
    if (!RESET_N) begin
      addr_ff <= '0;
    end else begin
      addr_ff <= nxt_addr; // [RQ15]
    end
  end

  // Bytes are stored as they arrive; the timer only models the busy window.
  always_ff @(posedge LINK.scl) begin
    if (mem_we) begin
      mem[addr_ff] <= new_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data out changes on the falling edge, while SCL is low.

  always_ff @(negedge LINK.scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= link_ff.drive_low; // [RQ2]
    end
  end

  assign LINK.dev_sda_oe  = oe_ff;
  assign LINK.dev_sda_out = 1'b0;

endmodule // eeprom_device

// file: eeprom_host.sv
module eeprom_host
  import eeprom_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       RESET_N,
  input  wire logic       CMD_VALID,
  output logic            CMD_READY,
  input  wire cmd_type    CMD_CODE,
  input  wire logic [7:0] CMD_DATA,
  input  wire logic       CMD_LAST,
  output logic            RSP_VALID,
  output logic [7:0]      RSP_DATA,
  output logic            RSP_NACK,
  eeprom_link_if.host     LINK
);

  localparam logic [SCL_QW-1:0] Q_LAST = SCL_QW'(SCL_QUARTER_CYCLES - 1);

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BYTE  = 4'h4,
    H_STOP  = 4'h8
  } host_state_type;

  typedef struct packed {
    host_state_type    state;
    logic [1:0]        ph;
    logic [SCL_QW-1:0] qcnt;
    logic [3:0]        bit_n;
    logic [7:0]        tx;
    logic [7:0]        rx;
    logic              rd;
    logic              last;
    logic              scl;
    logic              sda_low;
    logic              rsp_valid;
    logic              rsp_nack;
    logic              sda_s1;
    logic              sda_s2;
  } host_regs_type;

  host_regs_type host_ff;
  host_regs_type nxt_host;
  logic          tick;

  // Returns {scl, sda pulled low} for one quarter of a bit time.
  function automatic logic [1:0] line_levels(input host_state_type s, input logic [1:0] ph,
                                             input logic [3:0] b, input logic tx7,
                                             input logic rd, input logic last);
    logic hi;
    hi = (ph == 2'h1) || (ph == 2'h2);
    case (s)
      H_START: return {hi, ph[1]}; // [RQ1] [RQ18]
      H_STOP:  return {ph != 2'h0, !ph[1]}; // [RQ1] [RQ8]
      default: return {hi, (b == ACK_SLOT) ? (rd && !last) : (!rd && !tx7)}; // [RQ2] [RQ20]
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_host           = host_ff;
    nxt_host.sda_s1    = LINK.sda;
    nxt_host.sda_s2    = host_ff.sda_s1;
    nxt_host.rsp_valid = 1'b0;
    tick               = (host_ff.qcnt == Q_LAST);
    case (host_ff.state)
      H_IDLE: begin
        nxt_host.qcnt = '0;
        nxt_host.ph   = 2'h0;
        if (CMD_VALID) begin
          nxt_host.bit_n    = 4'h0;
          nxt_host.rsp_nack = 1'b0;
          nxt_host.tx       = CMD_DATA;
          nxt_host.rd       = 1'b0;
          nxt_host.last     = CMD_LAST;
          case (CMD_CODE)
            CMD_START: nxt_host.state = H_START;
            CMD_STOP:  nxt_host.state = H_STOP;
            CMD_WRITE: nxt_host.state = H_BYTE;
            default: begin
              nxt_host.state = H_BYTE;
              nxt_host.rd    = 1'b1;
              nxt_host.tx    = 8'hff;
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          nxt_host.qcnt = '0;
          nxt_host.ph   = host_ff.ph + 2'h1;
          // Sample at the end of the high phase, well after SDA settled.
          if (host_ff.ph == 2'h2 && host_ff.state == H_BYTE) begin
            if (host_ff.bit_n == ACK_SLOT) begin
              nxt_host.rsp_nack = host_ff.sda_s2; // [RQ2] [RQ6]
            end else begin
              nxt_host.rx = {host_ff.rx[6:0], host_ff.sda_s2};
            end
          end
          if (host_ff.ph == 2'h3) begin
            if (host_ff.state == H_BYTE && host_ff.bit_n != ACK_SLOT) begin
              nxt_host.bit_n = host_ff.bit_n + 4'h1;
              nxt_host.tx    = {host_ff.tx[6:0], 1'b1};
            end else begin
              nxt_host.state     = H_IDLE;
              nxt_host.rsp_valid = 1'b1;
            end
          end
        end else begin
          nxt_host.qcnt = host_ff.qcnt + 1'b1;
        end
      end
    endcase
    if (nxt_host.state != H_IDLE) begin
      {nxt_host.scl, nxt_host.sda_low} = line_levels(nxt_host.state, nxt_host.ph,
                                                     nxt_host.bit_n, nxt_host.tx[7],
                                                     nxt_host.rd, nxt_host.last);
    end else if (host_ff.state == H_BYTE) begin
      // SCL stays low after a byte so a repeated start or a stop may follow.
      nxt_host.sda_low = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      host_ff       <= '0;
      host_ff.state <= H_IDLE;
      host_ff.scl   <= 1'b1;
    end else begin
      host_ff <= nxt_host;
    end
  end

  assign CMD_READY         = (host_ff.state == H_IDLE);
  assign RSP_VALID         = host_ff.rsp_valid;
  assign RSP_DATA          = host_ff.rx;
  assign RSP_NACK          = host_ff.rsp_nack;
  assign LINK.scl          = host_ff.scl;
  assign LINK.host_sda_oe  = host_ff.sda_low;
  assign LINK.host_sda_out = 1'b0;

endmodule // eeprom_host

// file: eeprom_monitor.sv
module eeprom_monitor
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic BUSY,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  typedef struct packed {
    logic        sda_q;
    logic        frame;
    logic [3:0]  stop_age;
    logic [31:0] busy_cnt;
  } mon_state_type;

  mon_state_type st_ff;
  mon_state_type nxt_st;
  logic          start_ev;
  logic          stop_ev;

  assign start_ev = scl && st_ff.sda_q && !sda;
  assign stop_ev  = scl && !st_ff.sda_q && sda;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sda_q = sda;
    if (start_ev) nxt_st.frame = 1'b1;
    if (stop_ev) nxt_st.frame = 1'b0;
    // The age saturates so a long idle gap never wraps into a false recent stop.
    if (stop_ev) nxt_st.stop_age = 4'h0;
    else if (st_ff.stop_age != 4'hf) nxt_st.stop_age = st_ff.stop_age + 4'h1;
    nxt_st.busy_cnt = BUSY ? st_ff.busy_cnt + 32'h1 : 32'h0;
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) st_ff <= '{sda_q: 1'b1, frame: 1'b0, stop_age: 4'hf, busy_cnt: 32'h0};
    else st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////
  default clocking mon_cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  start_hold_a: assert property (start_ev |-> scl[*8])
    else $error("scl fell too soon after a start");
  stop_hold_a: assert property (stop_ev |-> scl[*8])
    else $error("scl fell too soon after a stop");
  busy_len_a: assert property ($fell(BUSY) |-> st_ff.busy_cnt == PROG_CYCLES_P)
    else $error("programming window has the wrong length");
  busy_quiet_a: assert property (BUSY |-> !dev_sda_oe)
    else $error("device drove sda while programming");
  busy_launch_a: assert property ($rose(BUSY) |-> st_ff.stop_age <= 4'ha)
    else $error("programming began without a recent stop");
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device changed sda while scl high");
  idle_quiet_a: assert property (!st_ff.frame |-> !dev_sda_oe)
    else $error("device drove sda outside a frame");
  ack_stand_a: assert property ($rose(dev_sda_oe) |-> dev_sda_oe[*8])
    else $error("device low level too short");
  release_stand_a: assert property ($fell(dev_sda_oe) |-> !dev_sda_oe[*8])
    else $error("device release too short");

  start_cov_c: cover property (start_ev);
  host_ack_c: cover property ($rose(host_sda_oe) && !scl);
  busy_cov_c: cover property ($rose(BUSY));
  ack_cov_c: cover property ($rose(dev_sda_oe));
endmodule // eeprom_monitor

// file: two_wire_eeprom_access_protocol_tb.sv
module two_wire_eeprom_access_protocol_tb
  import eeprom_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // A long write window lets a few polls fall inside it.
  localparam int PROG_P = 3000;
  logic       ref_clk   = 1'b0;
  logic       reset_n   = 1'b0;
  logic [2:0] sel       = 3'h0;
  logic       cmd_valid = 1'b0;
  cmd_type    cmd_code  = CMD_START;
  logic [7:0] cmd_data  = 8'h00;
  logic       cmd_last  = 1'b0;
  logic       cmd_ready;
  logic       rsp_valid;
  logic       rsp_nack;
  logic       busy;
  logic [7:0] rsp_data;
  logic [7:0] mem [256];
  logic [7:0] cnt       = 8'h00;
  int         err_total = 0;
  int         compares  = 0;

  always #12.5 ref_clk = ~ref_clk;

  eeprom_link_if eeprom_link_if_i ();
  eeprom_host eeprom_host_i (.REF_CLK(ref_clk), .RESET_N(reset_n), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_CODE(cmd_code), .CMD_DATA(cmd_data), .CMD_LAST(cmd_last),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_NACK(rsp_nack),
    .LINK(eeprom_link_if_i.host));
  eeprom_device #(.PROG_CYCLES_P(PROG_P)) eeprom_device_i (.REF_CLK(ref_clk),
    .RESET_N(reset_n), .SELECT_PIN_HIGH(sel[2]), .SELECT_PIN_MID(sel[1]),
    .SELECT_PIN_LOW(sel[0]), .BUSY(busy), .LINK(eeprom_link_if_i.device));
  eeprom_monitor #(.PROG_CYCLES_P(PROG_P)) eeprom_monitor_i (.REF_CLK(ref_clk),
    .RESET_N(reset_n), .BUSY(busy), .scl(eeprom_link_if_i.scl), .sda(eeprom_link_if_i.sda),
    .host_sda_oe(eeprom_link_if_i.host_sda_oe), .dev_sda_oe(eeprom_link_if_i.dev_sda_oe));

  ////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input cmd_type c, input logic [7:0] d, input logic l);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_data  <= d;
    cmd_last  <= l;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) begin
      err_total++;
      final_report();
    end
  endtask

  function automatic logic [7:0] dev(input logic rw);
    return {DEV_TYPE_CODE, sel, rw};
  endfunction

  task automatic wb(input logic [7:0] b, input logic nack);
    cmd(CMD_WRITE, b, 1'b0);
    check({7'h0, rsp_nack}, {7'h0, nack});
  endtask

  task automatic poll();
    for (int k = 0; k < 12; k++) begin
      cmd(CMD_START, 8'h00, 1'b0);
      cmd(CMD_WRITE, dev(1'b0), 1'b0);
      if (k == 0) check({7'h0, rsp_nack}, 8'h01);
      if (rsp_nack === 1'b0) break;
      cmd(CMD_STOP, 8'h00, 1'b0);
    end
    check({7'h0, rsp_nack}, 8'h00);
    cmd(CMD_STOP, 8'h00, 1'b0);
  endtask

  task automatic wframe(input logic [7:0] a, input int n);
    logic [7:0] d;
    cmd(CMD_START, 8'h00, 1'b0);
    wb(dev(1'b0), 1'b0);
    wb(a, 1'b0);
    cnt = a;
    repeat (n) begin
      d = 8'($urandom);
      wb(d, 1'b0);
      mem[cnt] = d;
      cnt = {cnt[7:3], cnt[2:0] + 3'h1};
    end
    cmd(CMD_STOP, 8'h00, 1'b0);
    poll();
  endtask

  task automatic cread(input int n);
    cmd(CMD_START, 8'h00, 1'b0);
    wb(dev(1'b1), 1'b0);
    for (int i = 0; i < n; i++) begin
      cmd(CMD_READ, 8'h00, i == n - 1);
      check(rsp_data, mem[cnt]);
      cnt = cnt + 8'h1;
    end
    cmd(CMD_STOP, 8'h00, 1'b0);
  endtask

  task automatic rread(input logic [7:0] a, input int n);
    cmd(CMD_START, 8'h00, 1'b0);
    wb(dev(1'b0), 1'b0);
    wb(a, 1'b0);
    cnt = a;
    cread(n);
  endtask

  task automatic mismatch();
    logic [7:0] bad;
    for (int i = 0; i < 4; i++) begin
      bad = (i < 3) ? {4'ha, sel ^ (3'h1 << i), 1'b0} : {4'h2, sel, 1'b1};
      cmd(CMD_START, 8'h00, 1'b0);
      wb(bad, 1'b1);
      // A matching address inside the ignored frame must still go unanswered.
      wb(dev(1'b0), 1'b1);
      check(rsp_data, dev(1'b0));
      cmd(CMD_STOP, 8'h00, 1'b0);
      check({7'h0, busy}, 8'h00);
    end
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h52c7));
    @(posedge ref_clk);
    sel <= 3'($urandom);
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    wframe(8'h00, 1);
    wframe(8'hfe, 9);
    cread(2);
    rread(8'hfa, 2);
    mismatch();
    rread(8'h00, 1);
    final_report();
  end
endmodule // two_wire_eeprom_access_protocol_tb
